/* File: logic/adc_clk_divider.sv */
// conversion clock tick generator dividing the peripheral clock
`timescale 1ns/1ps
`default_nettype none
module adc_clk_divider
   import adc_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_enable,
   input  wire logic [2:0] i_ratio,
   output logic            o_tick
);

   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       tick_q;
   logic       tick_d;

   // counter restarts while disabled so the first tick is a full period after start
   always_comb
   begin
      cnt_d  = '0;
      tick_d = 1'b0;
      if (i_enable)
      begin
         if (cnt_q == ratio_divisor(i_ratio) - 4'h1)
         begin
            tick_d = 1'b1;
         end
         else
         begin
            cnt_d = cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign o_tick = tick_q;

endmodule
`default_nettype wire

/* File: logic/adc_pkg.sv */
// constants, types and helper functions for the converter control block
// How it works
// - band 00: conversion clock is peripheral clock divided by 12,8,6,4,3,2
// - band 00: 2 clear, 6 sample, 12 convert, 2 interrupt conversion clocks
// - band 01: same dividers, sampling stretched to 24 conversion clocks
// - result word is 16 bits, low 6 bits always zero
// - approximation register copied into result word at every conversion end
// - upper 8 result bits at ff09, lower 2 in ff08 bits 7:6; word readable
// - reset clears the result word
// - 8-bit high-byte register holds upper 8 result bits, reset to 00
// - writes to mode, channel or pin registers may spoil result contents
// - every result read inserts one wait cycle
// - conversion runs while the run bit is 1, halts when 0
// - ratio and band fields sit in mode register bits 5 to 1
// - conversions repeat back to back while enabled
// - conversion-done request raised at every conversion end
package adc_pkg;

   // byte addresses on the peripheral bus
   localparam logic [15:0] ADDR_RESULT_WORD = 16'hff08;
   localparam logic [15:0] ADDR_RESULT_HIGH = 16'hff09;
   localparam logic [15:0] ADDR_MODE        = 16'hff28;
   localparam logic [15:0] ADDR_CHANNEL     = 16'hff29;
   localparam logic [15:0] ADDR_PIN_CONFIG  = 16'hff2f;

   // mode register fields
   localparam int MODE_RUN_BIT   = 7;
   localparam int MODE_RATIO_MSB = 5;
   localparam int MODE_RATIO_LSB = 3;
   localparam int MODE_BAND_MSB  = 2;
   localparam int MODE_BAND_LSB  = 1;
   localparam int MODE_CMP_BIT   = 0;

   // writable bit masks and reset values
   localparam logic [7:0]  MODE_WMASK    = 8'hbf;
   localparam logic [7:0]  CHANNEL_WMASK = 8'h07;
   localparam logic [7:0]  PINCFG_WMASK  = 8'h0f;
   localparam logic [7:0]  REG8_RESET    = 8'h00;
   localparam logic [15:0] RESULT_RESET  = 16'h0000;

   // result layout
   localparam int RES_BITS     = 10;
   localparam int RESULT_SHIFT = 6;

   // phase lengths in conversion clocks
   localparam logic [4:0] CLEAR_TICKS       = 5'h02;
   localparam logic [4:0] SAMPLE_TICKS_HIGH = 5'h06;
   localparam logic [4:0] SAMPLE_TICKS_LOW  = 5'h18;
   localparam logic [4:0] CONV_TICKS        = 5'h0c;
   localparam logic [4:0] IRQ_TICKS         = 5'h02;
   localparam logic [1:0] BAND_HIGH         = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_CLEAR  = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_CONV   = 3'b011,
      ST_IRQ    = 3'b100
   } conv_state_t;

   // peripheral clocks per conversion clock; prohibited codes fall back to the slowest
   function automatic logic [3:0] ratio_divisor(input logic [2:0] code);
      case (code)
         3'h0:    ratio_divisor = 4'hc;
         3'h1:    ratio_divisor = 4'h8;
         3'h2:    ratio_divisor = 4'h6;
         3'h3:    ratio_divisor = 4'h4;
         3'h4:    ratio_divisor = 4'h3;
         3'h5:    ratio_divisor = 4'h2;
         default: ratio_divisor = 4'hc;
      endcase
   endfunction

   // sampling length; only band 00 gets the short window
   function automatic logic [4:0] sample_ticks(input logic [1:0] band);
      sample_ticks = (band == BAND_HIGH) ? SAMPLE_TICKS_HIGH : SAMPLE_TICKS_LOW;
   endfunction

   // peripheral clocks in one whole conversion
   function automatic logic [9:0] conversion_clocks(input logic [2:0] code, input logic [1:0] band);
      logic [5:0] ticks;
      ticks = 6'(CLEAR_TICKS) + 6'(sample_ticks(band)) + 6'(CONV_TICKS) + 6'(IRQ_TICKS);
      conversion_clocks = 10'(ratio_divisor(code)) * 10'(ticks);
   endfunction

endpackage

/* File: logic/adc_timing_and_result_regs.sv */
// converter control: mode registers, conversion sequencer and result registers
`timescale 1ns/1ps
`default_nettype none
module adc_timing_and_result_regs
   import adc_pkg::*;
(
   input  wire logic          i_core_clk,
   input  wire logic          i_rst_n,
   input  wire logic [15:0]   i_addr,
   input  wire logic          i_wr_en,
   input  wire logic [7:0]    i_wdata,
   input  wire logic          i_rd_en,
   input  wire logic          i_rd_word,
   input  wire logic          i_cmp_above,
   output logic      [15:0]   o_rdata,
   output logic               o_rd_valid,
   output logic               o_wait,
   output logic      [9:0]    o_dac_code,
   output logic               o_sampling,
   output logic               o_cmp_enable,
   output logic      [2:0]    o_channel,
   output logic      [3:0]    o_pin_config,
   output logic               o_conversion_done_irq
);

   // ---------------- register file ----------------
   logic [7:0]  conv_mode_reg_q, conv_mode_reg_d;
   logic [7:0]  channel_select_reg_q, channel_select_reg_d;
   logic [7:0]  pin_config_reg_q, pin_config_reg_d;
   logic [15:0] conversion_result_word_q, conversion_result_word_d;
   logic [7:0]  conversion_result_high_q, conversion_result_high_d;

   logic [15:0] rdata_q, rdata_d;
   logic        rd_valid_q, rd_valid_d;
   logic        wait_q, wait_d;
   logic        rd_pend_q, rd_pend_d;
   logic [15:0] pend_data_q, pend_data_d;

   logic        conversion_run;
   logic [2:0]  clock_ratio_sel;
   logic [1:0]  supply_band_sel;
   logic        result_load;
   logic [RES_BITS-1:0] sar_value;

   assign conversion_run  = conv_mode_reg_q[MODE_RUN_BIT];
   assign clock_ratio_sel = conv_mode_reg_q[MODE_RATIO_MSB:MODE_RATIO_LSB];
   assign supply_band_sel = conv_mode_reg_q[MODE_BAND_MSB:MODE_BAND_LSB];

   // byte read decode; a word read at the result address returns the whole word
   function automatic logic [15:0] read_mux(input logic [15:0] addr, input logic word,
                                            input logic [15:0] res_word, input logic [7:0] res_high,
                                            input logic [7:0] mode, input logic [7:0] chan,
                                            input logic [7:0] pins);
      case (addr)
         ADDR_RESULT_WORD: read_mux = word ? res_word : {8'h00, res_word[7:0]};
         ADDR_RESULT_HIGH: read_mux = {8'h00, res_high};
         ADDR_MODE:        read_mux = {8'h00, mode};
         ADDR_CHANNEL:     read_mux = {8'h00, chan};
         ADDR_PIN_CONFIG:  read_mux = {8'h00, pins};
         default:          read_mux = 16'h0000;
      endcase
   endfunction

   function automatic logic is_result_addr(input logic [15:0] addr);
      is_result_addr = (addr == ADDR_RESULT_WORD) || (addr == ADDR_RESULT_HIGH);
   endfunction

   // register writes and result loading; writes never touch the results, so a
   // mid-conversion write only spoils the value being built, not the stored one
   always_comb
   begin
      conv_mode_reg_d          = conv_mode_reg_q;
      channel_select_reg_d     = channel_select_reg_q;
      pin_config_reg_d         = pin_config_reg_q;
      conversion_result_word_d = conversion_result_word_q;
      conversion_result_high_d = conversion_result_high_q;
      if (i_wr_en)
      begin
         case (i_addr)
            ADDR_MODE:       conv_mode_reg_d      = i_wdata & MODE_WMASK;
            ADDR_CHANNEL:    channel_select_reg_d = i_wdata & CHANNEL_WMASK;
            ADDR_PIN_CONFIG: pin_config_reg_d     = i_wdata & PINCFG_WMASK;
            default:         conv_mode_reg_d      = conv_mode_reg_q;
         endcase
      end
      if (result_load)
      begin
         conversion_result_word_d = {sar_value, {RESULT_SHIFT{1'b0}}};
         conversion_result_high_d = sar_value[RES_BITS-1 -: 8];
      end
   end

   // reads: result registers answer one cycle later, after a wait cycle
   always_comb
   begin
      rdata_d     = rdata_q;
      rd_valid_d  = 1'b0;
      wait_d      = 1'b0;
      rd_pend_d   = 1'b0;
      pend_data_d = pend_data_q;
      if (rd_pend_q)
      begin
         rdata_d    = pend_data_q;
         rd_valid_d = 1'b1;
      end
      else if (i_rd_en)
      begin
         if (is_result_addr(i_addr))
         begin
            wait_d      = 1'b1;
            rd_pend_d   = 1'b1;
            pend_data_d = read_mux(i_addr, i_rd_word, conversion_result_word_q, conversion_result_high_q,
                                   conv_mode_reg_q, channel_select_reg_q, pin_config_reg_q);
         end
         else
         begin
            rdata_d    = read_mux(i_addr, i_rd_word, conversion_result_word_q, conversion_result_high_q,
                                  conv_mode_reg_q, channel_select_reg_q, pin_config_reg_q);
            rd_valid_d = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         conv_mode_reg_q          <= REG8_RESET;
         channel_select_reg_q     <= REG8_RESET;
         pin_config_reg_q         <= REG8_RESET;
         conversion_result_word_q <= RESULT_RESET;
         conversion_result_high_q <= REG8_RESET;
         rdata_q                  <= RESULT_RESET;
         rd_valid_q               <= 1'b0;
         wait_q                   <= 1'b0;
         rd_pend_q                <= 1'b0;
         pend_data_q              <= RESULT_RESET;
      end
      else
      begin
         conv_mode_reg_q          <= conv_mode_reg_d;
         channel_select_reg_q     <= channel_select_reg_d;
         pin_config_reg_q         <= pin_config_reg_d;
         conversion_result_word_q <= conversion_result_word_d;
         conversion_result_high_q <= conversion_result_high_d;
         rdata_q                  <= rdata_d;
         rd_valid_q               <= rd_valid_d;
         wait_q                   <= wait_d;
         rd_pend_q                <= rd_pend_d;
         pend_data_q              <= pend_data_d;
      end
   end

   // ---------------- conversion sequencer ----------------
   conv_state_t state_q, state_d;
   logic [4:0]  ph_cnt_q, ph_cnt_d;
   logic        tick;
   logic        sar_step;
   logic [3:0]  bit_idx;
   logic [4:0]  ph_len;
   logic        ph_last;
   logic [9:0]  dac_q, dac_d, sar_next;
   logic        sampling_q, sampling_d;
   logic        done_q, done_d;

   adc_clk_divider u_div (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_enable   (state_q != ST_IDLE),
      .i_ratio    (clock_ratio_sel),
      .o_tick     (tick)
   );

   sar_register #(.W(RES_BITS)) u_sar (
      .i_core_clk  (i_core_clk),
      .i_rst_n     (i_rst_n),
      .i_clear     (state_q == ST_CLEAR),
      .i_step      (sar_step),
      .i_bit_idx   (bit_idx),
      .i_cmp_above (i_cmp_above),
      .o_sar       (sar_value)
   );

   // length of the current phase in conversion clocks
   always_comb
   begin
      case (state_q)
         ST_CLEAR:  ph_len = CLEAR_TICKS;
         ST_SAMPLE: ph_len = sample_ticks(supply_band_sel);
         ST_CONV:   ph_len = CONV_TICKS;
         ST_IRQ:    ph_len = IRQ_TICKS;
         default:   ph_len = CLEAR_TICKS;
      endcase
   end

   // bits are decided MSB first on the first ten clocks of the convert phase
   assign ph_last     = tick && (ph_cnt_q == ph_len - 5'h01);
   assign bit_idx     = 4'(RES_BITS - 1) - ph_cnt_q[3:0];
   assign sar_step    = (state_q == ST_CONV) && tick && (ph_cnt_q < 5'(RES_BITS));
   assign result_load = (state_q == ST_CONV) && ph_last;

   always_comb
   begin
      state_d    = state_q;
      ph_cnt_d   = ph_cnt_q;
      done_d     = 1'b0;
      if (!conversion_run)
      begin
         state_d  = ST_IDLE;
         ph_cnt_d = '0;
      end
      else if (tick || state_q == ST_IDLE)
      begin
         ph_cnt_d = ph_last ? 5'h00 : ph_cnt_q + 5'h01;
         case (state_q)
            ST_IDLE:   begin state_d = ST_CLEAR; ph_cnt_d = '0; end
            ST_CLEAR:  if (ph_last) state_d = ST_SAMPLE;
            ST_SAMPLE: if (ph_last) state_d = ST_CONV;
            ST_CONV:   if (ph_last) begin state_d = ST_IRQ; done_d = 1'b1; end
            ST_IRQ:    if (ph_last) state_d = ST_CLEAR;
            default:   state_d = ST_IDLE;
         endcase
      end
      sampling_d = (state_d == ST_SAMPLE);
      // next trial shows from the deciding edge on, so divide-by-2 still leaves a settle cycle
      sar_next   = sar_value;
      if (sar_step)
         sar_next[bit_idx] = i_cmp_above;
      dac_d      = sar_next;
      if (state_d == ST_CONV && ph_cnt_d < 5'(RES_BITS))
      begin
         dac_d = sar_next | (10'h001 << (4'(RES_BITS - 1) - ph_cnt_d[3:0]));
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         state_q    <= ST_IDLE;
         ph_cnt_q   <= '0;
         done_q     <= 1'b0;
         sampling_q <= 1'b0;
         dac_q      <= '0;
      end
      else
      begin
         state_q    <= state_d;
         ph_cnt_q   <= ph_cnt_d;
         done_q     <= done_d;
         sampling_q <= sampling_d;
         dac_q      <= dac_d;
      end
   end

   assign o_rdata               = rdata_q;
   assign o_rd_valid            = rd_valid_q;
   assign o_wait                = wait_q;
   assign o_dac_code            = dac_q;
   assign o_sampling            = sampling_q;
   assign o_cmp_enable          = conv_mode_reg_q[MODE_CMP_BIT];
   assign o_channel             = channel_select_reg_q[2:0];
   assign o_pin_config          = pin_config_reg_q[3:0];
   assign o_conversion_done_irq = done_q;

   // ---------------- checks ----------------
   // clocks since the last done pulse, valid once one full conversion was seen
   logic [9:0] since_done_q;
   logic       seen_done_q;
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         since_done_q <= '0;
         seen_done_q  <= 1'b0;
      end
      else
      begin
         since_done_q <= done_q ? 10'h000 : since_done_q + 10'h001;
         seen_done_q  <= (done_q || seen_done_q) && conversion_run && !(i_wr_en && i_addr == ADDR_MODE);
      end
   end

   property p_conv_length;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (done_q && seen_done_q) |-> since_done_q == conversion_clocks(clock_ratio_sel, supply_band_sel) - 10'h001;
   endproperty
   a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");
   property p_phase_order;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (state_q == ST_CLEAR && ph_last && conversion_run) |=> state_q == ST_SAMPLE;
   endproperty
   a_phase_order: assert property (p_phase_order) else $error("clear phase not followed by sampling");
   property p_low_bits_zero;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      conversion_result_word_q[RESULT_SHIFT-1:0] == '0;
   endproperty
   a_low_bits_zero: assert property (p_low_bits_zero) else $error("result low bits not zero");
   property p_result_loaded;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      done_q |-> conversion_result_word_q[15:RESULT_SHIFT] == sar_value;
   endproperty
   a_result_loaded: assert property (p_result_loaded) else $error("result not copied at done");
   property p_high_matches;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      conversion_result_high_q == conversion_result_word_q[15:8];
   endproperty
   a_high_matches: assert property (p_high_matches) else $error("high byte mismatch");
   property p_reset_clears;
      @(posedge i_core_clk)
      !i_rst_n |=> conversion_result_word_q == RESULT_RESET && !done_q;
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear result");

   property p_read_wait;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_rd_en && !rd_pend_q && is_result_addr(i_addr)) |=> o_wait && !o_rd_valid ##1 o_rd_valid;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("result read without wait cycle");

   property p_stop;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !conversion_run |=> state_q == ST_IDLE && !done_q;
   endproperty
   a_stop: assert property (p_stop) else $error("conversion did not halt");

   property p_repeat;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (state_q == ST_IRQ && ph_last && conversion_run) |=> state_q == ST_CLEAR;
   endproperty
   a_repeat: assert property (p_repeat) else $error("conversion did not restart");

   property p_done_pulse;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      done_q |-> $past(state_q) == ST_CONV && state_q == ST_IRQ ##1 !done_q;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done request misplaced");

endmodule
`default_nettype wire

/* File: logic/sar_register.sv */
// successive approximation register, one bit decided per step
`timescale 1ns/1ps
`default_nettype none
module sar_register
   import adc_pkg::*;
#(
   parameter int W = RES_BITS
)
(
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_clear,
   input  wire logic         i_step,
   input  wire logic [3:0]   i_bit_idx,
   input  wire logic         i_cmp_above,
   output logic     [W-1:0]  o_sar
);

   logic [W-1:0] sar_q;
   logic [W-1:0] sar_d;

   // comparator said sample is above the trial level: keep the bit
   always_comb
   begin
      sar_d = sar_q;
      if (i_clear)
      begin
         sar_d = '0;
      end
      else if (i_step)
      begin
         sar_d[i_bit_idx] = i_cmp_above;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         sar_q <= '0;
      end
      else
      begin
         sar_q <= sar_d;
      end
   end

   assign o_sar = sar_q;

endmodule
`default_nettype wire

/* File: tb/tb_adc_timing_and_result_regs.sv */
// self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_timing_and_result_regs
   import adc_pkg::*;
;
   logic        i_core_clk  = 1'b0;
   logic        i_rst_n     = 1'b0;
   logic [15:0] i_addr      = 16'h0000;
   logic        i_wr_en     = 1'b0;
   logic [7:0]  i_wdata     = 8'h00;
   logic        i_rd_en     = 1'b0;
   logic        i_rd_word   = 1'b0;
   logic        i_cmp_above = 1'b0;
   logic [15:0] o_rdata;
   logic        o_rd_valid;
   logic        o_wait;
   logic [9:0]  o_dac_code;
   logic        o_sampling;
   logic        o_cmp_enable;
   logic [2:0]  o_channel;
   logic [3:0]  o_pin_config;
   logic        o_conversion_done_irq;
   logic [9:0]  vin = 10'h000;
   logic [15:0] d;
   int          fail_count = 0;
   int          tests_run  = 0;
   int          n;
   int          pulses;
   int          samp;
   int          divs[6] = '{12, 8, 6, 4, 3, 2};

   adc_timing_and_result_regs dut
   (
      .i_core_clk            (i_core_clk),
      .i_rst_n               (i_rst_n),
      .i_addr                (i_addr),
      .i_wr_en               (i_wr_en),
      .i_wdata               (i_wdata),
      .i_rd_en               (i_rd_en),
      .i_rd_word             (i_rd_word),
      .i_cmp_above           (i_cmp_above),
      .o_rdata               (o_rdata),
      .o_rd_valid            (o_rd_valid),
      .o_wait                (o_wait),
      .o_dac_code            (o_dac_code),
      .o_sampling            (o_sampling),
      .o_cmp_enable          (o_cmp_enable),
      .o_channel             (o_channel),
      .o_pin_config          (o_pin_config),
      .o_conversion_done_irq (o_conversion_done_irq)
   );

   // 100 mhz peripheral clock
   initial
   begin
      forever #5 i_core_clk = ~i_core_clk;
   end

   // analog input model; registered comparator says above when vin is at or above the trial code
   always @(posedge i_core_clk)
   begin
      i_cmp_above <= (vin >= o_dac_code);
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (fail_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // one-cycle byte write strobe
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge i_core_clk);
      i_addr  <= a;
      i_wdata <= v;
      i_wr_en <= 1'b1;
      @(posedge i_core_clk);
      i_wr_en <= 1'b0;
   endtask

   // read strobe; waits bounded for the answer and notes whether a wait cycle came first
   task automatic rd(input logic [15:0] a, input logic w, input logic res, output logic [15:0] q);
      logic sw;
      int   k;
      logic got;
      sw  = 1'b0;
      got = 1'b0;
      k   = 0;
      q   = 16'hxxxx;
      @(posedge i_core_clk);
      i_addr    <= a;
      i_rd_word <= w;
      i_rd_en   <= 1'b1;
      @(posedge i_core_clk);
      i_rd_en   <= 1'b0;
      i_rd_word <= 1'b0;
      while (k < 6 && !got)
      begin
         @(posedge i_core_clk);
         k++;
         if (o_wait === 1'b1)
            sw = 1'b1;
         if (o_rd_valid === 1'b1)
         begin
            got = 1'b1;
            q   = o_rdata;
         end
      end
      check({15'h0000, sw}, {15'h0000, res});
   endtask

   // edges until the next done pulse, bounded so a silent design cannot hang; sampling cycles counted too
   task automatic wait_done(output int cnt, output int sc);
      cnt = 0;
      sc  = 0;
      do
      begin
         @(posedge i_core_clk);
         cnt++;
         if (o_sampling === 1'b1)
            sc++;
      end
      while (o_conversion_done_irq !== 1'b1 && cnt < 3000);
   endtask

   // watchdog well beyond the longest expected run
   initial
   begin
      #500000;
      fail_count++;
      wrap_up();
   end

   // main sequence
   initial
   begin
      void'($urandom(32'h7109bbca));
      repeat (12) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      rd(ADDR_RESULT_WORD, 1'b1, 1'b1, d);
      check(d, 16'h0000);
      wr(ADDR_RESULT_HIGH, 8'h5a);
      rd(ADDR_RESULT_HIGH, 1'b0, 1'b1, d);
      check(d, 16'h0000);
      rd(16'hff00, 1'b0, 1'b0, d);
      check(d, 16'h0000);
      // bit 6 is not writable, prohibited ratio code 7 is stored as written
      wr(ADDR_MODE, 8'h7f);
      rd(ADDR_MODE, 1'b0, 1'b0, d);
      check(d, 16'h003f);
      check({15'h0000, o_cmp_enable}, 16'h0001);
      wr(ADDR_CHANNEL, 8'hff);
      wr(ADDR_PIN_CONFIG, 8'hff);
      rd(ADDR_CHANNEL, 1'b0, 1'b0, d);
      check(d, 16'h0007);
      rd(ADDR_PIN_CONFIG, 1'b0, 1'b0, d);
      check(d, 16'h000f);
      check({9'h000, o_channel, o_pin_config}, 16'h007f);
      wr(ADDR_MODE, 8'h00);
      // ratio codes 0 to 5 in both supply bands
      for (int r = 0; r < 6; r++)
      begin
         for (int b = 0; b < 2; b++)
         begin
            vin = 10'($urandom);
            wr(ADDR_MODE, 8'(8'h81 | (r << 3) | (b << 1)));
            wait_done(n, samp);
            wait_done(n, samp);
            check(16'(n), 16'(divs[r] * (b ? 40 : 22)));
            check(16'(samp), 16'(divs[r] * (b ? 24 : 6)));
            rd(ADDR_RESULT_WORD, 1'b1, 1'b1, d);
            check(d, {vin, 6'h00});
            rd(ADDR_RESULT_HIGH, 1'b0, 1'b1, d);
            check(d, {8'h00, vin[9:2]});
            rd(ADDR_RESULT_WORD, 1'b0, 1'b1, d);
            check(d, {8'h00, vin[1:0], 6'h00});
            // results are read before the mode is touched again
            wr(ADDR_MODE, 8'h00);
            pulses = 0;
            repeat (500)
            begin
               @(posedge i_core_clk);
               if (o_conversion_done_irq !== 1'b0)
                  pulses++;
            end
            check(16'(pulses), 16'h0000);
         end
      end
      wrap_up();
   end
endmodule
`default_nettype wire
